// ### core/stsu_regs.vh
// Constants for the status, trigger and self test unit.
// Assumes one 100 MHz clock shared with the command parser and module bus.
`ifndef STSU_REGS_VH
`define STSU_REGS_VH
// ----------------------------------------------------------------
// Command codes from the parser
// ----------------------------------------------------------------
`define STSU_C_RST 4'h0
`define STSU_C_SREW 4'h1
`define STSU_C_SREQ 4'h2
`define STSU_C_STBQ 4'h3
`define STSU_C_TRG 4'h4
`define STSU_C_GET 4'h5
`define STSU_C_INIT 4'h6
`define STSU_C_CON 4'h7
`define STSU_C_COFF 4'h8
`define STSU_C_TST 4'h9
`define STSU_C_WAI 4'hA
`define STSU_C_OPC 4'hB
// ----------------------------------------------------------------
// Status byte bit positions and resets
// ----------------------------------------------------------------
`define STSU_B_OPERATION_SUMMARY 7
`define STSU_B_MSS 6
`define STSU_B_ESB 5
`define STSU_B_MAV 4
`define STSU_B_QUESTIONABLE_SUMMARY 3
`define STSU_B_ERRQ 2
`define STSU_SRE_RST 8'h00
`define STSU_SRE_WMASK 8'hBF
`define STSU_LVL_ZERO 16'h0000
// ----------------------------------------------------------------
// Module bus operations and self test layout
// ----------------------------------------------------------------
`define STSU_OP_OFF 4'h0
`define STSU_OP_PMAX 4'h1
`define STSU_OP_MEAS 4'h2
`define STSU_OP_ZERO 4'h3
`define STSU_OP_RNEG 4'h4
`define STSU_OP_NMAX 4'h5
`define STSU_OP_RPOS 4'h6
`define STSU_STEP_LAST 4'h9
`define STSU_ADDR_FIRST 5'h01
`define STSU_ADDR_LAST 5'h1F
`endif

// ### core/stsu_core.v
// Status byte, service request, trigger, self test and wait sequencing.
// Assumes a command parser, status sources and the module bus master
// all run on clk, so no input needs a synchroniser.
//
// Contract
// - Reset command zeroes setpoints, output off.
// - Reset command clears latched protection state.
// - Enable mask accepts 0..255, bit 6 ignored.
// - Summary bit is OR of enabled status.
// - Status byte bit layout as defined.
// - Mask query returns current mask.
// - Status query returns summary, clears nothing.
// - Serial poll returns request flag, clears it.
// - Armed trigger loads trigger levels, disarms.
// - Continuous arming re-arms after each trigger.
// - Triggers act only when addressed listener.
// - Self test runs the relay level sequence.
// - Self test errors set supply questionable flags.
// - Test answer zero or failing supply addresses.
// - Wait command holds commands until idle.
// - All settings volatile, lost at power loss.
// - Completion command flags when all done.
// - Single arm allows exactly one trigger.
// - Reset command turns continuous arming off.
`timescale 1ns/1ps
`include "stsu_regs.vh"

module stsu_core (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Command port
    input wire cmd_valid,
    input wire [3:0] cmd_code,
    input wire [7:0] cmd_data,
    output reg cmd_ready_q,
    input wire listen_i,
    // Status sources
    input wire operation_summary,
    input wire event_summary_bit,
    input wire message_waiting,
    input wire questionable_summary,
    input wire error_queue_nonempty,
    input wire level_busy,
    // Serial poll
    input wire spoll_req,
    output reg poll_valid_q,
    output reg [7:0] poll_data_q,
    // Query answers
    output reg rsp_valid_q,
    output reg [7:0] rsp_data_q,
    output reg rsp_last_q,
    // Trigger levels and output control
    input wire [15:0] trigger_voltage_level,
    input wire [15:0] trigger_current_level,
    output reg [15:0] volt_set_q,
    output reg [15:0] curr_set_q,
    output reg output_switch_q,
    output reg prot_clr_q,
    // Register and flag view
    output reg [7:0] sre_q,
    output reg [7:0] stb_q,
    output reg service_request_flag_q,
    output reg trigger_armed_flag_q,
    output reg continuous_arming_q,
    output reg opc_done_q,
    // Module bus
    input wire [31:0] sup_present,
    output reg mb_req_q,
    output reg [3:0] mb_op_q,
    output reg [4:0] mb_addr_q,
    input wire mb_ack,
    input wire mb_err,
    input wire questionable_summary_clr,
    input wire [4:0] questionable_summary_clr_addr,
    output reg [31:0] questionable_summary_flags_q
);

    // ----------------------------------------------------------------
    // Self test states
    // ----------------------------------------------------------------
    localparam [1:0] T_IDLE = 2'b00;
    localparam [1:0] T_ISSUE = 2'b01;
    localparam [1:0] T_WAIT = 2'b10;
    localparam [1:0] T_REPORT = 2'b11;

    reg [1:0] t_state_q;
    reg [3:0] step_q;
    reg [4:0] addr_q;
    reg any_fail_q;
    reg wait_q;
    reg opc_pend_q;
    wire take;
    wire trig_take;
    wire master_summary;
    wire poll_take;

    // A command is taken only while ready was offered.
    assign take = cmd_valid && cmd_ready_q;
    assign trig_take = take && listen_i &&
        (cmd_code == `STSU_C_TRG || cmd_code == `STSU_C_GET);
    assign master_summary = |({operation_summary, event_summary_bit, message_waiting,
        questionable_summary, error_queue_nonempty} &
        {sre_q[`STSU_B_OPERATION_SUMMARY], sre_q[`STSU_B_ESB], sre_q[`STSU_B_MAV],
        sre_q[`STSU_B_QUESTIONABLE_SUMMARY], sre_q[`STSU_B_ERRQ]});
    assign poll_take = spoll_req;

    // Maps a self test step onto a module bus operation.
    function [3:0] step_op;
        input [3:0] s;
        begin
            case (s)
                4'h0: step_op = `STSU_OP_OFF;
                4'h1: step_op = `STSU_OP_PMAX;
                4'h2: step_op = `STSU_OP_MEAS;
                4'h3: step_op = `STSU_OP_ZERO;
                4'h4: step_op = `STSU_OP_MEAS;
                4'h5: step_op = `STSU_OP_RNEG;
                4'h6: step_op = `STSU_OP_NMAX;
                4'h7: step_op = `STSU_OP_MEAS;
                4'h8: step_op = `STSU_OP_ZERO;
                default: step_op = `STSU_OP_RPOS;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Status byte and service request
    // ----------------------------------------------------------------
    // The request flag is a rising-summary latch; a new reason arriving in
    // the poll cycle sets it again, so no request is ever lost.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stb_q <= 8'h00;
            service_request_flag_q <= 1'b0;
            poll_valid_q <= 1'b0;
            poll_data_q <= 8'h00;
        end
        else
        begin
            stb_q <= {operation_summary, master_summary, event_summary_bit, message_waiting,
                questionable_summary, error_queue_nonempty, 2'b00};
            poll_valid_q <= poll_take;
            if (poll_take)
                poll_data_q <= {stb_q[7], service_request_flag_q, stb_q[5:0]};
            if (master_summary && !stb_q[`STSU_B_MSS])
                service_request_flag_q <= 1'b1;
            else if (poll_take)
                service_request_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Per-supply questionable flags
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1)
        begin : g_questionable_summary
            // Errors found during the test win over a same-cycle host clear.
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    questionable_summary_flags_q[gi] <= 1'b0;
                else if (t_state_q == T_WAIT && mb_ack && mb_err && addr_q == gi)
                    questionable_summary_flags_q[gi] <= 1'b1;
                else if (questionable_summary_clr && questionable_summary_clr_addr == gi)
                    questionable_summary_flags_q[gi] <= 1'b0;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Commands, trigger, wait and completion
    // ----------------------------------------------------------------
    // volatile settings
    // Every setting lives in flip-flops and returns to its default at reset.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sre_q <= `STSU_SRE_RST;
            volt_set_q <= `STSU_LVL_ZERO;
            curr_set_q <= `STSU_LVL_ZERO;
            output_switch_q <= 1'b0;
            prot_clr_q <= 1'b0;
            trigger_armed_flag_q <= 1'b0;
            continuous_arming_q <= 1'b0;
            wait_q <= 1'b0;
            opc_pend_q <= 1'b0;
            opc_done_q <= 1'b0;
        end
        else
        begin
            prot_clr_q <= 1'b0;
            opc_done_q <= 1'b0;
            if (take && cmd_code == `STSU_C_WAI)
                wait_q <= 1'b1;
            else if (!level_busy)
                wait_q <= 1'b0;
            if (take && cmd_code == `STSU_C_OPC)
                opc_pend_q <= 1'b1;
            else if (opc_pend_q && !level_busy)
            begin
                opc_pend_q <= 1'b0;
                opc_done_q <= 1'b1;
            end
            if (take && cmd_code == `STSU_C_RST)
            begin
                volt_set_q <= `STSU_LVL_ZERO;
                curr_set_q <= `STSU_LVL_ZERO;
                output_switch_q <= 1'b0;
                prot_clr_q <= 1'b1;
                continuous_arming_q <= 1'b0;
                trigger_armed_flag_q <= 1'b0;
            end
            if (take && cmd_code == `STSU_C_SREW)
                sre_q <= cmd_data & `STSU_SRE_WMASK;
            if (take && cmd_code == `STSU_C_INIT)
                trigger_armed_flag_q <= 1'b1;
            if (take && cmd_code == `STSU_C_CON)
            begin
                continuous_arming_q <= 1'b1;
                trigger_armed_flag_q <= 1'b1;
            end
            if (take && cmd_code == `STSU_C_COFF)
                continuous_arming_q <= 1'b0;
            if (trig_take && trigger_armed_flag_q)
            begin
                volt_set_q <= trigger_voltage_level;
                curr_set_q <= trigger_current_level;
                trigger_armed_flag_q <= continuous_arming_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // Self test sequencer, query answers and command ready
    // ----------------------------------------------------------------
    // Supplies are tested one after another; the host sees no ready until
    // the whole report has gone out, which keeps answers in order.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t_state_q <= T_IDLE;
            step_q <= 4'h0;
            addr_q <= `STSU_ADDR_FIRST;
            any_fail_q <= 1'b0;
            mb_req_q <= 1'b0;
            mb_op_q <= `STSU_OP_OFF;
            mb_addr_q <= 5'h00;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 8'h00;
            rsp_last_q <= 1'b0;
            cmd_ready_q <= 1'b0;
        end
        else
        begin
            rsp_valid_q <= 1'b0;
            rsp_last_q <= 1'b0;
            mb_req_q <= 1'b0;
            cmd_ready_q <= (t_state_q == T_IDLE) && !wait_q && !(take &&
                (cmd_code == `STSU_C_WAI || cmd_code == `STSU_C_TST));
            if (take && cmd_code == `STSU_C_SREQ)
            begin
                rsp_valid_q <= 1'b1;
                rsp_data_q <= sre_q;
                rsp_last_q <= 1'b1;
            end
            if (take && cmd_code == `STSU_C_STBQ)
            begin
                rsp_valid_q <= 1'b1;
                rsp_data_q <= stb_q;
                rsp_last_q <= 1'b1;
            end
            case (t_state_q)
                T_IDLE:
                begin
                    if (take && cmd_code == `STSU_C_TST)
                    begin
                        t_state_q <= T_ISSUE;
                        step_q <= 4'h0;
                        addr_q <= `STSU_ADDR_FIRST;
                        any_fail_q <= 1'b0;
                    end
                end
                T_ISSUE:
                begin
                    if (sup_present[addr_q])
                    begin
                        mb_req_q <= 1'b1;
                        mb_op_q <= step_op(step_q);
                        mb_addr_q <= addr_q;
                        t_state_q <= T_WAIT;
                    end
                    else if (addr_q == `STSU_ADDR_LAST)
                    begin
                        addr_q <= `STSU_ADDR_FIRST;
                        t_state_q <= T_REPORT;
                    end
                    else
                        addr_q <= addr_q + 5'h01;
                end
                T_WAIT:
                begin
                    if (mb_ack)
                    begin
                        t_state_q <= T_ISSUE;
                        if (step_q != `STSU_STEP_LAST)
                            step_q <= step_q + 4'h1;
                        else
                        begin
                            step_q <= 4'h0;
                            if (addr_q == `STSU_ADDR_LAST)
                            begin
                                addr_q <= `STSU_ADDR_FIRST;
                                t_state_q <= T_REPORT;
                            end
                            else
                                addr_q <= addr_q + 5'h01;
                        end
                    end
                end
                T_REPORT:
                begin
                    if (questionable_summary_flags_q[addr_q])
                    begin
                        rsp_valid_q <= 1'b1;
                        rsp_data_q <= {3'b000, addr_q};
                        any_fail_q <= 1'b1;
                    end
                    if (addr_q == `STSU_ADDR_LAST)
                    begin
                        rsp_last_q <= 1'b1;
                        if (!questionable_summary_flags_q[addr_q] && !any_fail_q)
                        begin
                            rsp_valid_q <= 1'b1;
                            rsp_data_q <= 8'h00;
                        end
                        t_state_q <= T_IDLE;
                    end
                    else
                        addr_q <= addr_q + 5'h01;
                end
                default:
                    t_state_q <= T_IDLE;
            endcase
        end
    end

endmodule // stsu_core

// ### bench/stsu_core_properties.sv
// Concurrent checks on the status, trigger and self test core.
// Assumes it is bound onto stsu_core and sees only its ports.
`timescale 1ns/1ps
`include "stsu_regs.vh"
module stsu_core_properties (
    // Clock, reset and command port
    input wire clk,
    input wire rst_n,
    input wire cmd_valid,
    input wire [3:0] cmd_code,
    input wire [7:0] cmd_data,
    input wire cmd_ready_q,
    input wire listen_i,
    input wire level_busy,
    // Status sources
    input wire operation_summary,
    input wire event_summary_bit,
    input wire message_waiting,
    input wire questionable_summary,
    input wire error_queue_nonempty,
    // Answers, registers and levels
    input wire rsp_valid_q,
    input wire [7:0] rsp_data_q,
    input wire [7:0] sre_q,
    input wire [7:0] stb_q,
    input wire [15:0] trigger_voltage_level,
    input wire [15:0] trigger_current_level,
    input wire [15:0] volt_set_q,
    input wire [15:0] curr_set_q,
    input wire output_switch_q,
    input wire prot_clr_q,
    input wire trigger_armed_flag_q,
    input wire continuous_arming_q,
    input wire opc_done_q
);
    // ------------------------------------------------------------
    // Helpers and assertions
    // ------------------------------------------------------------
    // The status byte is registered, so every check looks one cycle back.
    wire take = cmd_valid && cmd_ready_q;
    wire trg = take && (cmd_code == `STSU_C_TRG || cmd_code == `STSU_C_GET);
    wire [7:0] src = {operation_summary, 1'b0, event_summary_bit, message_waiting,
        questionable_summary, error_queue_nonempty, 2'b00};
    wire any_en = |(src & sre_q);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_mask_write: assert property (take && cmd_code == `STSU_C_SREW
        |=> sre_q == ($past(cmd_data) & `STSU_SRE_WMASK)) else $error("Mask write wrong");
    a_stb_layout: assert property ((stb_q & 8'hBF) == $past(src))
        else $error("Status layout wrong");
    a_summary_or: assert property (stb_q[6] == $past(any_en))
        else $error("Summary bit wrong");
    a_mask_query: assert property (take && cmd_code == `STSU_C_SREQ
        |=> rsp_valid_q && rsp_data_q == $past(sre_q)) else $error("Mask answer wrong");
    a_stb_query: assert property (take && cmd_code == `STSU_C_STBQ
        |=> rsp_valid_q && rsp_data_q == $past(stb_q)) else $error("Status answer wrong");
    a_reset_cmd: assert property (take && cmd_code == `STSU_C_RST
        |=> volt_set_q == 16'h0000 && curr_set_q == 16'h0000 && !output_switch_q
        && !continuous_arming_q && prot_clr_q) else $error("Reset command wrong");
    a_trig_load: assert property (trg && listen_i && trigger_armed_flag_q
        |=> volt_set_q == $past(trigger_voltage_level) && curr_set_q ==
        $past(trigger_current_level) && trigger_armed_flag_q == $past(continuous_arming_q))
        else $error("Trigger load wrong");
    a_trig_deaf: assert property (trg && !listen_i
        |=> $stable(volt_set_q) && $stable(trigger_armed_flag_q)) else $error("Trigger acted");
    a_wait_refuse: assert property (take && cmd_code == `STSU_C_WAI
        |=> !cmd_ready_q) else $error("Wait not held");
    a_opc_idle: assert property (opc_done_q |-> !$past(level_busy))
        else $error("Completion while busy");
endmodule // stsu_core_properties
bind stsu_core stsu_core_properties i_stsu_core_properties (.clk, .rst_n, .cmd_valid,
    .cmd_code, .cmd_data, .cmd_ready_q, .listen_i, .level_busy, .operation_summary,
    .event_summary_bit, .message_waiting, .questionable_summary, .error_queue_nonempty,
    .rsp_valid_q, .rsp_data_q, .sre_q, .stb_q, .trigger_voltage_level, .trigger_current_level,
    .volt_set_q, .curr_set_q, .output_switch_q, .prot_clr_q, .trigger_armed_flag_q,
    .continuous_arming_q, .opc_done_q);

// ### bench/stsu_mbus_model.sv
// Module bus model: the attached supplies answering each request.
// Assumes single-cycle requests whose op and address stand until the next.
`timescale 1ns/1ps
`include "stsu_regs.vh"
module stsu_mbus_model #(
    parameter FAIL_ADDR = 5'h05
) (
    // Request side
    input wire clk,
    input wire mb_req_q,
    input wire [3:0] mb_op_q,
    input wire [4:0] mb_addr_q,
    input wire fail_en,
    // Answer side
    output logic mb_ack,
    output logic mb_err
);
    // Requests are logged; answers alternate prompt and slow.
    logic [8:0] op_log[$];
    logic busy = 1'b0;
    logic slow = 1'b0;
    logic [1:0] wait_cnt = 2'h0;
    initial mb_ack = 1'b0;
    initial mb_err = 1'b0;
    always @(posedge clk)
    begin
        mb_ack <= 1'b0;
        mb_err <= 1'b0;
        if (mb_req_q === 1'b1)
        begin
            op_log.push_back({mb_addr_q, mb_op_q});
            busy <= 1'b1;
            wait_cnt <= slow ? 2'h3 : 2'h0;
            slow <= !slow;
        end
        else if (busy && wait_cnt != 2'h0)
            wait_cnt <= wait_cnt - 2'h1;
        else if (busy)
        begin
            busy <= 1'b0;
            mb_ack <= 1'b1;
            mb_err <= fail_en && mb_addr_q == FAIL_ADDR && mb_op_q == `STSU_OP_MEAS;
        end
    end
endmodule // stsu_mbus_model

// ### bench/stsu_core_tb.sv
// Self-checking bench for the status, trigger and self test core.
// Assumes the module bus model answers every module bus request.
`timescale 1ns/1ps
`include "stsu_regs.vh"
module stsu_core_tb;
    // ------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------
    logic clk, rst_n, cmd_valid, listen_i, level_busy, spoll_req, questionable_summary_clr, fail_en;
    logic [3:0] cmd_code;
    logic [7:0] cmd_data, ev;
    logic [4:0] src, questionable_summary_clr_addr;
    logic [15:0] trigger_voltage_level, trigger_current_level;
    logic [31:0] sup_present;
    wire operation_summary = src[4], event_summary_bit = src[3], message_waiting = src[2];
    wire questionable_summary = src[1], error_queue_nonempty = src[0];
    wire cmd_ready_q, poll_valid_q, rsp_valid_q, rsp_last_q, output_switch_q, prot_clr_q;
    wire service_request_flag_q, trigger_armed_flag_q, continuous_arming_q, opc_done_q;
    wire mb_req_q, mb_ack, mb_err;
    wire [3:0] mb_op_q;
    wire [4:0] mb_addr_q;
    wire [7:0] poll_data_q, rsp_data_q, sre_q, stb_q;
    wire [15:0] volt_set_q, curr_set_q;
    wire [31:0] questionable_summary_flags_q;
    int error_cnt = 0, n_compared = 0, cyc = 0, n_last = 0, n_prot = 0, n_opc = 0, k, j, m;
    logic [7:0] rsp_q[$], poll_q[$];
    logic [7:0] mv[4] = '{8'hFF, 8'h40, 8'h00, 8'h28};
    logic [7:0] bv[5] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h80};
    logic [3:0] seq[10] = '{`STSU_OP_OFF, `STSU_OP_PMAX, `STSU_OP_MEAS, `STSU_OP_ZERO,
        `STSU_OP_MEAS, `STSU_OP_RNEG, `STSU_OP_NMAX, `STSU_OP_MEAS, `STSU_OP_ZERO, `STSU_OP_RPOS};
    stsu_core i_stsu_core (.clk, .rst_n, .cmd_valid, .cmd_code, .cmd_data, .cmd_ready_q,
        .listen_i, .operation_summary, .event_summary_bit, .message_waiting,
        .questionable_summary, .error_queue_nonempty, .level_busy, .spoll_req, .poll_valid_q,
        .poll_data_q, .rsp_valid_q, .rsp_data_q, .rsp_last_q, .trigger_voltage_level,
        .trigger_current_level, .volt_set_q, .curr_set_q, .output_switch_q, .prot_clr_q,
        .sre_q, .stb_q, .service_request_flag_q, .trigger_armed_flag_q, .continuous_arming_q,
        .opc_done_q, .sup_present, .mb_req_q, .mb_op_q, .mb_addr_q, .mb_ack, .mb_err,
        .questionable_summary_clr, .questionable_summary_clr_addr, .questionable_summary_flags_q);
    stsu_mbus_model #(.FAIL_ADDR(5'h05)) i_stsu_mbus_model (.clk, .mb_req_q, .mb_op_q,
        .mb_addr_q, .fail_en, .mb_ack, .mb_err);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pulses are collected mid-cycle, clear of the edge that launched them.
    always @(negedge clk)
    begin
        if (rsp_valid_q === 1'b1)
            rsp_q.push_back(rsp_data_q);
        if (poll_valid_q === 1'b1)
            poll_q.push_back(poll_data_q);
        n_last += (rsp_last_q === 1'b1);
        n_prot += (prot_clr_q === 1'b1);
        n_opc += (opc_done_q === 1'b1);
    end
    // A hang ends the run; the whole sequence needs well under a thousand cycles.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Offers a command, holds it until taken, then lets one cycle pass.
    task automatic cmd(input logic [3:0] c, input logic [7:0] d);
        int n = 0;
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_data <= d;
        do @(posedge clk); while (cmd_ready_q !== 1'b1 && n++ < 3000);
        // A command that is never taken is a failure, not a silent skip.
        if (n > 3000)
            error_cnt++;
        cmd_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poll();
        spoll_req <= 1'b1;
        @(posedge clk);
        spoll_req <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst_n, cmd_valid, listen_i, level_busy, spoll_req, questionable_summary_clr, fail_en} = 7'h00;
        {cmd_code, cmd_data, src, questionable_summary_clr_addr} = 22'h0;
        trigger_voltage_level = 16'h1234;
        trigger_current_level = 16'h0567;
        sup_present = 32'h0000_0024;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("defaults", 33'h0, {sre_q, volt_set_q, curr_set_q, output_switch_q});
        for (k = 0; k < 4; k++)
        begin
            rsp_q.delete();
            m = n_last;
            cmd(`STSU_C_SREW, mv[k]);
            cmd(`STSU_C_SREQ, 8'h00);
            chk("mask", {8'h01, mv[k] & 8'hBF}, {rsp_q.size(), rsp_q[0]});
            chk("last", m + 1, n_last);
        end
        for (k = 0; k < 5; k++)
        begin
            src <= 5'h01 << k;
            rsp_q.delete();
            repeat (2) @(posedge clk);
            cmd(`STSU_C_STBQ, 8'h00);
            cmd(`STSU_C_STBQ, 8'h00);
            ev = bv[k] | ((bv[k] & 8'h28) != 8'h00 ? 8'h40 : 8'h00);
            chk("status", {ev, ev}, {rsp_q[0], rsp_q[1]});
        end
        src <= 5'h08;
        repeat (3) @(posedge clk);
        poll();
        poll();
        chk("poll", 25'hC040C0, {poll_q[0], poll_q[1], stb_q, service_request_flag_q});
        cmd(`STSU_C_SREW, 8'h00);
        repeat (2) @(posedge clk);
        chk("summary", 8'h20, stb_q);
        src <= 5'h00;
        cmd(`STSU_C_INIT, 8'h00);
        cmd(`STSU_C_TRG, 8'h00);
        chk("deaf", 17'h1, {volt_set_q, trigger_armed_flag_q});
        listen_i <= 1'b1;
        cmd(`STSU_C_TRG, 8'h00);
        chk("trig", 33'h2468_0ACE, {volt_set_q, curr_set_q, trigger_armed_flag_q});
        trigger_voltage_level <= 16'h0ABC;
        cmd(`STSU_C_GET, 8'h00);
        chk("once", 32'h1234_0567, {volt_set_q, curr_set_q});
        cmd(`STSU_C_CON, 8'h00);
        cmd(`STSU_C_GET, 8'h00);
        chk("cont", 34'h2_AF01_59F, {volt_set_q, curr_set_q, trigger_armed_flag_q,
            continuous_arming_q});
        n_prot = 0;
        cmd(`STSU_C_RST, 8'h00);
        chk("reset", 36'h1, {volt_set_q, curr_set_q, output_switch_q, trigger_armed_flag_q,
            continuous_arming_q, n_prot == 1});
        cmd(`STSU_C_CON, 8'h00);
        cmd(`STSU_C_COFF, 8'h00);
        cmd(`STSU_C_GET, 8'h00);
        chk("coff", 18'h2AF0, {volt_set_q, continuous_arming_q, trigger_armed_flag_q});
        level_busy <= 1'b1;
        cmd(`STSU_C_WAI, 8'h00);
        repeat (8) @(posedge clk);
        chk("held", 1'b0, cmd_ready_q);
        level_busy <= 1'b0;
        cmd(`STSU_C_SREQ, 8'h00);
        level_busy <= 1'b1;
        n_opc = 0;
        cmd(`STSU_C_OPC, 8'h00);
        repeat (6) @(posedge clk);
        chk("early", 0, n_opc);
        level_busy <= 1'b0;
        repeat (4) @(posedge clk);
        chk("done", 1, n_opc);
        for (k = 0; k < 3; k++)
        begin
            fail_en <= (k == 1);
            rsp_q.delete();
            i_stsu_mbus_model.op_log.delete();
            m = n_last;
            cmd(`STSU_C_TST, 8'h00);
            for (j = 0; j < 3000 && n_last == m; j++)
                @(posedge clk);
            chk("test", {8'h01, k == 1 ? 8'h05 : 8'h00}, {rsp_q.size(), rsp_q[0]});
            chk("flags", k == 1 ? 32'h20 : 32'h0, questionable_summary_flags_q);
            chk("ops", 20, i_stsu_mbus_model.op_log.size());
            for (j = 0; j < 20; j++)
                chk("op", {j < 10 ? 5'h02 : 5'h05, seq[j % 10]}, i_stsu_mbus_model.op_log[j]);
            questionable_summary_clr <= 1'b1;
            questionable_summary_clr_addr <= 5'h05;
            @(posedge clk);
            questionable_summary_clr <= 1'b0;
        end
        end_of_test();
    end
endmodule // stsu_core_tb
